// File: src/pmc_power_ctrl.sv
// CPU power-mode controller: power control register, Idle and Stop modes.
// Assumes the CPU core drives a special-register write/read port on clk_in
// and pulses instr_done_in when the current instruction completes.
// Interrupt request, watchdog and detector inputs come from logic on clk_in;
// only the external reset pin is asynchronous.
`timescale 1ns/10ps
`default_nettype none
module pmc_power_ctrl
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ext_reset_in,
    input wire logic reg_wr_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic instr_done_in,
    input wire logic irq_masked_in,
    input wire logic watchdog_expired_in,
    input wire logic watchdog_en_in,
    input wire logic mcd_en_in,
    output logic [7:0] reg_rdata_out,
    output logic cpu_clk_en_out,
    output logic periph_clk_en_out,
    output logic osc_en_out,
    output logic baud_doubler_out,
    output logic irq_wake_out,
    output logic sys_reset_out,
    output logic [15:0] reset_pc_out
);
    ////////////////////////////////////////////////////////////////////////
    // Controller state, registered as one word
    typedef struct packed
    {
        pmc_pkg::pmc_mode_type mode;
        logic idle_pend;
        logic stop_pend;
        logic baud_doubler;
        logic [4:0] software_flags;
        logic [pmc_pkg::MCD_CNT_W-1:0] mcd_cnt;
        logic [7:0] rdata;
        logic cpu_en;
        logic per_en;
        logic osc_en;
        logic wake;
        logic sreset;
    } pmc_state_type;

    localparam logic [pmc_pkg::MCD_CNT_W-1:0] MCD_LAST =
        pmc_pkg::MCD_CNT_W'(pmc_pkg::MCD_CYCLES - 1);
    localparam logic [pmc_pkg::MCD_CNT_W-1:0] MCD_STEP = pmc_pkg::MCD_CNT_W'(1);

    // State after any reset: running, every clock on, register cleared
    localparam pmc_state_type STATE_RESET = '{
        mode: pmc_pkg::PMC_RUN,
        idle_pend: 1'b0,
        stop_pend: 1'b0,
        baud_doubler: pmc_pkg::PWR_CTRL_RESET[pmc_pkg::BAUD_BIT],
        software_flags: pmc_pkg::PWR_CTRL_RESET[pmc_pkg::FLAG_HI:pmc_pkg::FLAG_LO],
        mcd_cnt: '0,
        rdata: pmc_pkg::PWR_CTRL_RESET,
        cpu_en: 1'b1,
        per_en: 1'b1,
        osc_en: 1'b1,
        wake: 1'b0,
        sreset: 1'b0
    };

    // Oscillator-fed clocks run in every mode but Stop
    function automatic logic osc_running(input pmc_pkg::pmc_mode_type mode);
        osc_running = (mode != pmc_pkg::PMC_STOP);
    endfunction : osc_running

    pmc_state_type state_r;
    pmc_state_type state_nxt;
    logic ext_reset_sync;
    logic wr_hit;

    ////////////////////////////////////////////////////////////////////////
    // External reset pin crossing
    pmc_sync u_rst_sync
    (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .d_in(ext_reset_in),
        .q_out(ext_reset_sync)
    );

    // Write decode for the power control register
    assign wr_hit = reg_wr_in && (reg_addr_in == pmc_pkg::PWR_CTRL_ADDR);

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb
    begin
        state_nxt = state_r;
        state_nxt.wake = 1'b0;
        state_nxt.sreset = 1'b0;
        // Register write: flags and baud stored, mode bits latch a request
        if (wr_hit)
        begin
            state_nxt.baud_doubler = reg_wdata_in[pmc_pkg::BAUD_BIT];
            state_nxt.software_flags =
                reg_wdata_in[pmc_pkg::FLAG_HI:pmc_pkg::FLAG_LO];
            state_nxt.idle_pend = reg_wdata_in[pmc_pkg::IDLE_BIT];
            state_nxt.stop_pend = reg_wdata_in[pmc_pkg::STOP_BIT];
        end

        // Mode sequencing
        unique case (state_r.mode)
            pmc_pkg::PMC_RUN:
            begin
                // Enter at end of setting instruction; stop takes precedence
                if (instr_done_in && (state_nxt.stop_pend || state_nxt.idle_pend))
                begin
                    if (state_nxt.stop_pend)
                        state_nxt.mode = pmc_pkg::PMC_STOP;
                    else
                        state_nxt.mode = pmc_pkg::PMC_IDLE;
                    // Requests are used up by the entry; detector starts afresh
                    state_nxt.idle_pend = 1'b0;
                    state_nxt.stop_pend = 1'b0;
                    state_nxt.mcd_cnt = '0;
                end
            end
            pmc_pkg::PMC_IDLE:
            begin
                // Masked request wakes regardless of priority
                if (irq_masked_in)
                begin
                    state_nxt.mode = pmc_pkg::PMC_RUN;
                    state_nxt.wake = 1'b1;
                end
                // Enabled watchdog expiry ends Idle through a reset
                if (watchdog_en_in && watchdog_expired_in)
                    state_nxt.sreset = 1'b1;
            end
            pmc_pkg::PMC_STOP:
            begin
                // Interrupts ignored; only detector counts
                if (mcd_en_in)
                begin
                    if (state_r.mcd_cnt == MCD_LAST)
                        state_nxt.sreset = 1'b1;
                    else
                        state_nxt.mcd_cnt = state_r.mcd_cnt + MCD_STEP;
                end
            end
            default:
                state_nxt.mode = pmc_pkg::PMC_RUN;
        endcase

        // External reset pin, after the synchroniser
        if (ext_reset_sync)
            state_nxt.sreset = 1'b1;

        // Internal or external reset restores run state and register
        if (state_nxt.sreset)
        begin
            state_nxt.mode = pmc_pkg::PMC_RUN;
            state_nxt.idle_pend = 1'b0;
            state_nxt.stop_pend = 1'b0;
            state_nxt.wake = 1'b0;
            {state_nxt.baud_doubler, state_nxt.software_flags} =
                pmc_pkg::PWR_CTRL_RESET[pmc_pkg::BAUD_BIT:pmc_pkg::FLAG_LO];
            state_nxt.mcd_cnt = '0;
        end

        // Mode bits read as zero; the rest mirrors the stored fields
        state_nxt.rdata = '0;
        state_nxt.rdata[pmc_pkg::BAUD_BIT] = state_nxt.baud_doubler;
        state_nxt.rdata[pmc_pkg::FLAG_HI:pmc_pkg::FLAG_LO] = state_nxt.software_flags;

        // Clock enables: only CPU clock gated in Idle
        state_nxt.cpu_en = (state_nxt.mode == pmc_pkg::PMC_RUN);
        state_nxt.per_en = osc_running(state_nxt.mode);
        state_nxt.osc_en = osc_running(state_nxt.mode);
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            state_r <= STATE_RESET;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from flops
    assign reg_rdata_out = state_r.rdata;
    assign cpu_clk_en_out = state_r.cpu_en;
    assign periph_clk_en_out = state_r.per_en;
    assign osc_en_out = state_r.osc_en;
    assign baud_doubler_out = state_r.baud_doubler;
    assign irq_wake_out = state_r.wake;
    assign sys_reset_out = state_r.sreset;

    // Restart address is fixed
    assign reset_pc_out = pmc_pkg::RESET_PC;
endmodule : pmc_power_ctrl
`default_nettype wire

// File: src/pmc_pkg.sv
// Constants and types for the CPU power-mode controller.
// Assumes an 8-bit special-register bus from the CPU core.
package pmc_pkg;
    localparam logic [7:0] PWR_CTRL_ADDR = 8'h87;
    localparam logic [7:0] PWR_CTRL_RESET = 8'h00;
    localparam int IDLE_BIT = 0;
    localparam int STOP_BIT = 1;
    localparam int FLAG_LO = 2;
    localparam int FLAG_HI = 6;
    localparam int BAUD_BIT = 7;
    localparam logic [7:0] RESET_VECTOR = 8'h00;
    localparam logic [15:0] RESET_PC = 16'h0000;
    // Missing clock detector timeout
    localparam int MCD_TIMEOUT_US = 100;
    localparam int CLK_MHZ = 100;
    localparam int MCD_CYCLES = MCD_TIMEOUT_US * CLK_MHZ;
    localparam int MCD_CNT_W = 14;

    typedef enum logic [1:0]
    {
        PMC_RUN = 2'b00,
        PMC_IDLE = 2'b01,
        PMC_STOP = 2'b10
    } pmc_mode_type;
endpackage : pmc_pkg

// File: src/pmc_sync.sv
// Two-flop synchroniser for one level.
// Assumes input is asynchronous to clk_in.
`timescale 1ns/10ps
`default_nettype none
module pmc_sync
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic d_in,
    output logic q_out
);
    logic meta_r;

    // First flop feeds only the second
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            meta_r <= 1'b0;
            q_out <= 1'b0;
        end
        else
        begin
            meta_r <= d_in;
            q_out <= meta_r;
        end
    end
endmodule : pmc_sync
`default_nettype wire

// File: verif/pmc_cpu_model.sv
// CPU core model: issues power control writes as whole instructions.
// Assumes the bench calls exec from one process, on clk_in.
`timescale 1ns/10ps
`default_nettype none
module pmc_cpu_model
(
    input wire logic clk_in,
    output logic reg_wr_out,
    output logic [7:0] reg_addr_out,
    output logic [7:0] reg_wdata_out,
    output logic instr_done_out
);
    initial {reg_wr_out, reg_addr_out, reg_wdata_out, instr_done_out} = '0;
    // One write instruction; a mode write halts the core, so none follows it
    task automatic exec(input logic [7:0] a, input logic [7:0] d, input logic done);
        @(negedge clk_in);
        {reg_wr_out, reg_addr_out, reg_wdata_out, instr_done_out} = {1'b1, a, d, done};
        @(negedge clk_in);
        reg_wr_out = 1'b0;
        reg_wdata_out = ~d; // Stale data inverted
        instr_done_out = 1'b0;
    endtask : exec
endmodule : pmc_cpu_model
`default_nettype wire

// File: verif/pmc_power_ctrl_properties.sv
// Checker for the power-mode controller ports.
// Assumes a bench that never overlaps a wake with an internal reset.
`timescale 1ns/10ps
`default_nettype none
module pmc_chk
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic reg_wr_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic instr_done_in,
    input wire logic irq_masked_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic cpu_clk_en_out,
    input wire logic periph_clk_en_out,
    input wire logic osc_en_out,
    input wire logic baud_doubler_out,
    input wire logic irq_wake_out,
    input wire logic sys_reset_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // Mode entry, wake and register read-back
    chk_idle_entry: assert property (reg_wr_in && reg_addr_in == 8'h87 && instr_done_in
        && reg_wdata_in[1:0] == 2'b01 && osc_en_out && !irq_masked_in |=> !cpu_clk_en_out)
        else $error("idle not entered");
    chk_stop_entry: assert property (reg_wr_in && reg_addr_in == 8'h87 && instr_done_in
        && reg_wdata_in[1] |=> !osc_en_out && !cpu_clk_en_out) else $error("stop not entered");
    chk_idle_periph: assert property (!cpu_clk_en_out && osc_en_out |-> periph_clk_en_out)
        else $error("peripheral clock lost in idle");
    chk_irq_wake: assert property (!cpu_clk_en_out && osc_en_out && irq_masked_in
        |=> cpu_clk_en_out && irq_wake_out) else $error("no interrupt wake");
    chk_stop_no_wake: assert property (!osc_en_out |=> !irq_wake_out)
        else $error("interrupt woke stop");
    chk_mode_zero: assert property (reg_rdata_out[1:0] == 2'b00)
        else $error("mode bits read nonzero");
    chk_baud_map: assert property (baud_doubler_out == reg_rdata_out[7])
        else $error("baud doubler mismatch");
    chk_flag_write: assert property (reg_wr_in && reg_addr_in == 8'h87 && cpu_clk_en_out
        |=> reg_rdata_out[7:2] == $past(reg_wdata_in[7:2])) else $error("flags not written");
    // Any internal reset restarts with clocks on and the register clear
    chk_reset_restart: assert property (sys_reset_out
        |-> cpu_clk_en_out && osc_en_out && reg_rdata_out == 8'h00) else $error("reset not clean");
endmodule : pmc_chk
bind pmc_power_ctrl pmc_chk u_chk
(
    .clk_in(clk_in),
    .rst_in(rst_in),
    .reg_wr_in(reg_wr_in),
    .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in),
    .instr_done_in(instr_done_in),
    .irq_masked_in(irq_masked_in),
    .reg_rdata_out(reg_rdata_out),
    .cpu_clk_en_out(cpu_clk_en_out),
    .periph_clk_en_out(periph_clk_en_out),
    .osc_en_out(osc_en_out),
    .baud_doubler_out(baud_doubler_out),
    .irq_wake_out(irq_wake_out),
    .sys_reset_out(sys_reset_out)
);
`default_nettype wire

// File: verif/pmc_power_ctrl_tb_top.sv
// Self-checking bench for the power-mode controller.
// Assumes the CPU model drives the register port; bench drives the rest.
`timescale 1ns/10ps
`default_nettype none
module pmc_power_ctrl_tb_top;
    logic clk_in, rst_in, ext_reset_in, irq_masked_in, watchdog_expired_in;
    logic watchdog_en_in, mcd_en_in, reg_wr, instr_done, cpu_en, per_en, osc_en;
    logic baud, wake, sys_rst;
    logic [7:0] addr, wdata, rdata;
    logic [15:0] pc;
    int n_mismatch = 0;
    int n_tests = 0;
    int i;
    // Rows: address, write data, expected read-back
    localparam logic [23:0] ROWS [4] = '{24'h877C7C, 24'h878080, 24'h87A8A8, 24'h86FFA8};
    pmc_cpu_model cpu (.clk_in(clk_in), .reg_wr_out(reg_wr), .reg_addr_out(addr),
        .reg_wdata_out(wdata), .instr_done_out(instr_done));
    pmc_power_ctrl dut (.clk_in(clk_in), .rst_in(rst_in), .ext_reset_in(ext_reset_in),
        .reg_wr_in(reg_wr), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .instr_done_in(instr_done), .irq_masked_in(irq_masked_in),
        .watchdog_expired_in(watchdog_expired_in), .watchdog_en_in(watchdog_en_in),
        .mcd_en_in(mcd_en_in), .reg_rdata_out(rdata), .cpu_clk_en_out(cpu_en),
        .periph_clk_en_out(per_en), .osc_en_out(osc_en), .baud_doubler_out(baud),
        .irq_wake_out(wake), .sys_reset_out(sys_rst), .reset_pc_out(pc));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : final_report
    // Clock and watchdog
    initial
    begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    initial
    begin
        #200us;
        n_mismatch++;
        final_report();
    end
    // Main sequence
    initial
    begin
        {rst_in, ext_reset_in, irq_masked_in, watchdog_expired_in, watchdog_en_in, mcd_en_in} = 6'h20;
        repeat (8) @(negedge clk_in);
        rst_in = 1'b0;
        chk({rdata, cpu_en, per_en, osc_en, baud, wake, sys_rst}, 14'h0038);
        for (i = 0; i < 4; i++)
        begin
            cpu.exec(ROWS[i][23:16], ROWS[i][15:8], 1'b0);
            chk({rdata, baud}, {ROWS[i][7:0], ROWS[i][7]});
        end
        cpu.exec(8'h87, 8'h29, 1'b1);
        chk({cpu_en, per_en, osc_en}, 3'b011);
        irq_masked_in = 1'b1;
        @(negedge clk_in);
        irq_masked_in = 1'b0;
        chk({cpu_en, wake, rdata}, {2'b11, 8'h28});
        // Idle with flags set; watchdog expiry counts only when enabled
        cpu.exec(8'h87, 8'h7D, 1'b1);
        chk({cpu_en, rdata}, {1'b0, 8'h7C});
        watchdog_expired_in = 1'b1;
        @(negedge clk_in);
        chk({sys_rst, cpu_en}, 2'b00);
        watchdog_en_in = 1'b1;
        @(negedge clk_in);
        watchdog_expired_in = 1'b0;
        chk(sys_rst, 1'b1);
        repeat (2) @(negedge clk_in);
        chk({cpu_en, rdata, pc}, {1'b1, 8'h00, 16'h0000});
        mcd_en_in = 1'b1;
        cpu.exec(8'h87, 8'h82, 1'b1);
        chk({osc_en, per_en, cpu_en, baud}, 4'h1);
        irq_masked_in = 1'b1;
        @(negedge clk_in);
        irq_masked_in = 1'b0;
        chk({wake, cpu_en}, 2'b00);
        for (i = 0; i < 10100 && sys_rst !== 1'b1; i++)
            @(negedge clk_in);
        chk(i >= 9990 && i <= 10010, 1'b1);
        repeat (2) @(negedge clk_in);
        chk({osc_en, rdata}, 9'h100);
        cpu.exec(8'h87, 8'h01, 1'b1);
        ext_reset_in = 1'b1;
        repeat (4) @(negedge clk_in);
        chk(sys_rst, 1'b1);
        ext_reset_in = 1'b0;
        repeat (2) @(negedge clk_in);
        chk({cpu_en, osc_en, pc}, {2'b11, 16'h0000});
        // Mid-run reset out of Stop with flags set
        cpu.exec(8'h87, 8'h7E, 1'b1);
        chk({osc_en, rdata}, 9'h07C);
        rst_in = 1'b1;
        @(negedge clk_in);
        rst_in = 1'b0;
        chk({cpu_en, osc_en, rdata}, 10'h300);
        final_report();
    end
endmodule : pmc_power_ctrl_tb_top
`default_nettype wire
